//--- design/vt_consts.vh
`ifndef VT_CONSTS_VH
`define VT_CONSTS_VH

// ************************************************************
// request flag bits
// ************************************************************
`define VT_FL_INV       2
`define VT_FL_SEL       4
`define VT_FL_ADR       5
`define VT_FL_OPT       6

// ************************************************************
// standard opcodes
// ************************************************************
`define VT_OP_INVENTORY 8'h01
`define VT_OP_QUIET     8'h02
`define VT_OP_RD_BLK    8'h20
`define VT_OP_WR_BLK    8'h21
`define VT_OP_RD_MULTI  8'h23
`define VT_OP_SELECT    8'h25
`define VT_OP_RTR       8'h26

// ************************************************************
// extended function bytes
// ************************************************************
`define VT_OP_RD_RF     8'hA0
`define VT_OP_WR_RF     8'hA1
`define VT_OP_RD_ID     8'hA2
`define VT_OP_WR_ID     8'hA3
`define VT_OP_RD_XM     8'hA4
`define VT_OP_WR_XM     8'hA5
`define VT_OP_SPI_CMD   8'hA6
`define VT_OP_SPI_ACMD  8'hA7
`define VT_OP_WR_XST    8'hA8
`define VT_OP_RD_XST    8'hA9
`define VT_OP_LOCK_DEV  8'hB0
`define VT_OP_ULCK_DEV  8'hB1
`define VT_OP_RELOAD    8'hC0
`define VT_OP_LOCK_PG   8'hD0
`define VT_OP_ULCK_PG   8'hD1

// ************************************************************
// reply flags and error codes
// ************************************************************
`define VT_RSP_OK       8'h00
`define VT_RSP_ERR      8'h01
`define VT_DSFID        8'h00
`define VT_ERR_OPT      8'h03
`define VT_ERR_ACC      8'h0F
`define VT_ERR_LOCK     8'h12

// ************************************************************
// access targets and lockable device index
// ************************************************************
`define VT_TGT_EE       3'h0
`define VT_TGT_RF       3'h1
`define VT_TGT_ID       3'h2
`define VT_TGT_XM       3'h3
`define VT_TGT_SPI      3'h4
`define VT_TGT_PAGE     3'h5
`define VT_TGT_RELOAD   3'h6
`define VT_DEV_EE       3'h0
`define VT_DEV_RF       3'h1

// ************************************************************
// sizes
// ************************************************************
`define VT_RX_BYTES     16
`define VT_TX_DEPTH     8
`define VT_UID_BITS     64

`endif

//--- design/vt_fifo.v
module vt_fifo #(
	parameter WIDTH = 9,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	input  wire             clk,
	input  wire             rst_n,
	input  wire             ce,
	input  wire             in_valid,
	input  wire [WIDTH-1:0] in_data,
	output wire             in_ready,
	output reg              out_valid,
	output reg  [WIDTH-1:0] out_data,
	input  wire             out_ready
);
	localparam [AW:0] FULL = DEPTH;

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wp;
	reg [AW-1:0]    rp;
	reg [AW:0]      cnt;
	wire            push;
	wire            load_out;

	// output stage is a register so the drain side never sees a mux
	assign in_ready = (cnt != FULL);
	assign push     = in_valid && in_ready;
	assign load_out = (cnt != {(AW+1){1'b0}}) && (!out_valid || out_ready);

	always @(posedge clk) begin
		if (ce && push) begin
			mem[wp] <= in_data;
		end
	end

	always @(posedge clk) begin
		if (!rst_n) begin
			wp        <= {AW{1'b0}};
			rp        <= {AW{1'b0}};
			cnt       <= {(AW+1){1'b0}};
			out_valid <= 1'b0;
			out_data  <= {WIDTH{1'b0}};
		end else if (ce) begin
			if (push) begin
				wp <= wp + 1'b1;
			end
			if (load_out) begin
				out_data  <= mem[rp];
				out_valid <= 1'b1;
				rp        <= rp + 1'b1;
			end else if (out_ready) begin
				out_valid <= 1'b0;
			end
			if (push && !load_out) begin
				cnt <= cnt + 1'b1;
			end else if (!push && load_out) begin
				cnt <= cnt - 1'b1;
			end
		end
	end
endmodule // vt_fifo

//--- design/vt_frame_buf.v
module vt_frame_buf #(
	parameter NB = 16
) (
	input  wire            clk,
	input  wire            rst_n,
	input  wire            ce,
	input  wire            clr,
	input  wire            wr,
	input  wire [7:0]      din,
	output wire [NB*8-1:0] bytes,
	output reg  [4:0]      cnt
);
	genvar i;

	generate
		for (i = 0; i < NB; i = i + 1) begin : g_byte
			localparam [4:0] IDX = i;
			reg [7:0] b;
			always @(posedge clk) begin
				if (!rst_n) begin
					b <= 8'h00;
				end else if (ce && wr && !clr && cnt == IDX) begin
					b <= din;
				end
			end
			assign bytes[i*8 +: 8] = b;
		end
	endgenerate

	// saturates so an overlong frame stays visible as overflow
	always @(posedge clk) begin
		if (!rst_n) begin
			cnt <= 5'h00;
		end else if (ce) begin
			if (clr) begin
				cnt <= 5'h00;
			end else if (wr && cnt != 5'h1F) begin
				cnt <= cnt + 5'h01;
			end
		end
	end
endmodule // vt_frame_buf

//--- design/vt_cmd_decoder.v
`include "vt_consts.vh"

module vt_cmd_decoder #(
	parameter [7:0] MFG_CODE = 8'h5A // arbitrary value
) (
	input  wire        clk,
	input  wire        rst_n,
	input  wire        ce,
	input  wire [63:0] uid,
	input  wire [7:0]  spi_wrsr_op,
	input  wire [7:0]  spi_rdsr_op,
	input  wire        rx_sof,
	input  wire        rx_valid,
	input  wire [7:0]  rx_data,
	input  wire        rx_eof,
	input  wire        rx_crc_ok,
	output wire        tx_valid,
	output wire [7:0]  tx_data,
	output wire        tx_last,
	input  wire        tx_ready,
	output reg         acc_req,
	output reg  [2:0]  acc_target,
	output reg         acc_write,
	output reg  [15:0] acc_addr,
	output reg  [15:0] acc_wdata,
	output reg  [7:0]  acc_spi_op,
	input  wire [15:0] acc_rdata,
	input  wire        acc_done,
	input  wire        acc_err,
	output reg  [7:0]  dev_lock,
	output reg         tag_quiet,
	output reg         tag_selected
);
	// ************************************************************
	// states and decode kinds
	// ************************************************************
	localparam [2:0] S_IDLE = 3'b001;
	localparam [2:0] S_ACC  = 3'b010;
	localparam [2:0] S_PUSH = 3'b100;

	localparam [2:0] K_DROP  = 3'h0;
	localparam [2:0] K_QUIET = 3'h1;
	localparam [2:0] K_INV   = 3'h2;
	localparam [2:0] K_PLAIN = 3'h3;
	localparam [2:0] K_LOCK  = 3'h4;
	localparam [2:0] K_EOPT  = 3'h5;
	localparam [2:0] K_ACC   = 3'h6;

	function [7:0] byte_at;
		input [127:0] v;
		input [4:0]   i;
		reg   [127:0] t;
		begin
			t = v >> {i, 3'b000};
			byte_at = t[7:0];
		end
	endfunction

	// ************************************************************
	// request capture and transmit queue
	// ************************************************************
	wire [127:0] fb;
	wire [4:0]   fcnt;
	wire         q_ready;
	reg  [2:0]   st;
	reg  [79:0]  rbuf;
	reg  [3:0]   rcnt;
	reg          rfinal;
	reg          rd_op;
	reg          first;
	reg  [7:0]   blk_left;

	vt_frame_buf #(.NB(`VT_RX_BYTES)) u_rx (
		.clk   (clk),
		.rst_n (rst_n),
		.ce    (ce),
		.clr   (rx_sof),
		.wr    (rx_valid && st == S_IDLE),
		.din   (rx_data),
		.bytes (fb),
		.cnt   (fcnt)
	);

	// full queue stalls the byte pusher, never drops a reply byte
	vt_fifo #(.WIDTH(9), .DEPTH(`VT_TX_DEPTH), .AW(3)) u_tx (
		.clk       (clk),
		.rst_n     (rst_n),
		.ce        (ce),
		.in_valid  (st == S_PUSH),
		.in_data   ({rfinal && rcnt == 4'h1, rbuf[7:0]}),
		.in_ready  (q_ready),
		.out_valid (tx_valid),
		.out_data  ({tx_last, tx_data}),
		.out_ready (tx_ready)
	);

	// ************************************************************
	// request decode
	// ************************************************************
	wire [7:0] fl  = byte_at(fb, 5'd0);
	wire [7:0] op  = byte_at(fb, 5'd1);
	wire       ext = (op[7:4] >= 4'hA) && (op[7:4] <= 4'hD);
	wire       inv = (op == `VT_OP_INVENTORY);
	wire       adr = fl[`VT_FL_ADR] && !inv;
	wire [4:0] hdr = ext ? 5'd3 : 5'd2;
	wire [4:0] p   = hdr + (adr ? 5'd8 : 5'd0);
	wire [127:0] uid_sh = fb >> {hdr, 3'b000};
	wire       uid_ok = !adr || (uid_sh[63:0] == uid);
	wire [7:0] a0 = byte_at(fb, p);
	wire [7:0] a1 = byte_at(fb, p + 5'd1);
	wire [7:0] a2 = byte_at(fb, p + 5'd2);
	wire [7:0] a3 = byte_at(fb, p + 5'd3);
	wire [7:0] mlen = byte_at(fb, 5'd2);
	wire [63:0] mval = fb[87:24];
	wire [63:0] mmask = (mlen >= 8'd64) ? {64{1'b1}} :
		((64'h1 << mlen[5:0]) - 64'h1);
	wire [4:0] mbytes = mlen[7:3] + {4'h0, |mlen[2:0]};
	wire       inv_hit = (mlen <= 8'd64) &&
		(((uid ^ mval) & mmask) == 64'h0);

	reg [2:0]  kind;
	reg [4:0]  nargs;
	reg [2:0]  d_tgt;
	reg        d_wr;
	reg        d_rd;
	reg [15:0] d_addr;
	reg [15:0] d_wdata;
	reg [7:0]  d_op;
	reg [2:0]  d_dev;

	always @* begin
		kind    = K_DROP;
		nargs   = 5'd0;
		d_tgt   = `VT_TGT_EE;
		d_wr    = 1'b0;
		d_rd    = 1'b0;
		d_addr  = {8'h00, a0};
		d_wdata = {a2, a1};
		d_op    = 8'h00;
		d_dev   = `VT_DEV_EE;
		case (op)
		`VT_OP_INVENTORY: begin
			nargs = mbytes + 5'd1;
			if (fl[`VT_FL_INV]) begin
				kind = K_INV;
			end
		end
		`VT_OP_QUIET: begin
			kind = K_QUIET;
		end
		`VT_OP_SELECT, `VT_OP_RTR: begin
			kind = K_PLAIN;
		end
		`VT_OP_RD_BLK, `VT_OP_RD_MULTI: begin
			kind  = K_ACC;
			nargs = (op == `VT_OP_RD_MULTI) ? 5'd2 : 5'd1;
			d_rd  = 1'b1;
		end
		`VT_OP_WR_BLK: begin
			nargs = 5'd3;
			d_wr  = 1'b1;
			kind  = fl[`VT_FL_OPT] ? K_ACC : K_EOPT;
		end
		`VT_OP_RD_RF, `VT_OP_WR_RF: begin
			kind  = K_ACC;
			d_tgt = `VT_TGT_RF;
			d_dev = `VT_DEV_RF;
			d_wr  = op[0];
			d_rd  = !op[0];
			nargs = op[0] ? 5'd3 : 5'd1;
		end
		`VT_OP_RD_ID, `VT_OP_WR_ID: begin
			kind  = K_ACC;
			d_tgt = `VT_TGT_ID;
			d_dev = a0[2:0];
			d_wr  = op[0];
			d_rd  = !op[0];
			nargs = op[0] ? 5'd3 : 5'd1;
		end
		`VT_OP_RD_XM, `VT_OP_WR_XM: begin
			kind    = K_ACC;
			d_tgt   = `VT_TGT_XM;
			d_addr  = {a1, a0};
			d_wdata = {a3, a2};
			d_wr    = op[0];
			d_rd    = !op[0];
			nargs   = op[0] ? 5'd4 : 5'd2;
		end
		`VT_OP_SPI_CMD, `VT_OP_SPI_ACMD: begin
			kind   = K_ACC;
			d_tgt  = `VT_TGT_SPI;
			d_op   = a0;
			d_addr = op[0] ? {a2, a1} : 16'h0000;
			d_wr   = 1'b1;
			nargs  = op[0] ? 5'd3 : 5'd1;
		end
		`VT_OP_WR_XST: begin
			kind    = K_ACC;
			d_tgt   = `VT_TGT_SPI;
			d_op    = spi_wrsr_op;
			d_wdata = {8'h00, a0};
			d_wr    = 1'b1;
			nargs   = 5'd1;
		end
		`VT_OP_RD_XST: begin
			kind  = K_ACC;
			d_tgt = `VT_TGT_SPI;
			d_op  = spi_rdsr_op;
			d_rd  = 1'b1;
		end
		`VT_OP_LOCK_DEV, `VT_OP_ULCK_DEV: begin
			kind  = K_LOCK;
			nargs = 5'd1;
		end
		`VT_OP_RELOAD: begin
			kind  = K_ACC;
			d_tgt = `VT_TGT_RELOAD;
			d_wr  = 1'b1;
		end
		`VT_OP_LOCK_PG, `VT_OP_ULCK_PG: begin
			kind  = K_ACC;
			d_tgt = `VT_TGT_PAGE;
			d_wr  = !op[0];
			nargs = 5'd1;
		end
		default: begin
			kind = K_DROP;
		end
		endcase
	end

	// drop anything damaged, short, foreign or not meant for us
	wire len_ok  = (fcnt <= 5'd16) && (fcnt >= p + nargs);
	wire mfg_ok  = !ext || (byte_at(fb, 5'd2) == MFG_CODE);
	wire quiet_ok = !tag_quiet || (op == `VT_OP_RTR);
	wire sel_ok  = inv || !fl[`VT_FL_SEL] || tag_selected;
	wire accept  = rx_eof && rx_crc_ok && kind != K_DROP && len_ok &&
		mfg_ok && uid_ok && quiet_ok && sel_ok;
	wire locked  = dev_lock[d_dev] && (d_tgt == `VT_TGT_EE ||
		d_tgt == `VT_TGT_RF || d_tgt == `VT_TGT_ID);

	// ************************************************************
	// sequencer
	// ************************************************************
	always @(posedge clk) begin
		if (!rst_n) begin
			st           <= S_IDLE;
			rbuf         <= 80'h0;
			rcnt         <= 4'h0;
			rfinal       <= 1'b0;
			rd_op        <= 1'b0;
			first        <= 1'b0;
			blk_left     <= 8'h00;
			acc_req      <= 1'b0;
			acc_target   <= `VT_TGT_EE;
			acc_write    <= 1'b0;
			acc_addr     <= 16'h0000;
			acc_wdata    <= 16'h0000;
			acc_spi_op   <= 8'h00;
			dev_lock     <= 8'h00;
			tag_quiet    <= 1'b0;
			tag_selected <= 1'b0;
		end else if (ce) begin
			case (st)
			S_IDLE: begin
				rfinal <= 1'b1;
				rcnt   <= 4'h1;
				rbuf   <= {72'h0, `VT_RSP_OK};
				if (accept) begin
					case (kind)
					K_QUIET: begin
						tag_quiet    <= 1'b1;
						tag_selected <= 1'b0;
					end
					K_INV: begin
						if (inv_hit) begin
							rbuf <= {uid, `VT_DSFID, `VT_RSP_OK};
							rcnt <= 4'hA;
							st   <= S_PUSH;
						end
					end
					K_PLAIN: begin
						tag_quiet    <= 1'b0;
						tag_selected <= (op == `VT_OP_SELECT);
						st           <= S_PUSH;
					end
					K_LOCK: begin
						dev_lock[a0[2:0]] <= !op[0];
						st                <= S_PUSH;
					end
					K_EOPT: begin
						rbuf <= {64'h0, `VT_ERR_OPT, `VT_RSP_ERR};
						rcnt <= 4'h2;
						st   <= S_PUSH;
					end
					default: begin
						if (locked) begin
							rbuf <= {64'h0, `VT_ERR_LOCK, `VT_RSP_ERR};
							rcnt <= 4'h2;
							st   <= S_PUSH;
						end else begin
							acc_req    <= 1'b1;
							acc_target <= d_tgt;
							acc_write  <= d_wr;
							acc_addr   <= d_addr;
							acc_wdata  <= d_wdata;
							acc_spi_op <= d_op;
							rd_op      <= d_rd;
							first      <= 1'b1;
							blk_left   <= (op == `VT_OP_RD_MULTI) ?
								a1 : 8'h00;
							st         <= S_ACC;
						end
					end
					endcase
				end
			end
			S_ACC: begin
				if (acc_done) begin
					acc_req <= 1'b0;
					first   <= 1'b0;
					rfinal  <= (blk_left == 8'h00);
					st      <= S_PUSH;
					if (acc_err && first) begin
						rbuf   <= {64'h0, `VT_ERR_ACC, `VT_RSP_ERR};
						rcnt   <= 4'h2;
						rfinal <= 1'b1;
					end else if (rd_op && first) begin
						rbuf <= {56'h0, acc_rdata, `VT_RSP_OK};
						rcnt <= 4'h3;
					end else if (rd_op) begin
						rbuf <= {64'h0, acc_rdata};
						rcnt <= 4'h2;
					end else begin
						rbuf <= {72'h0, `VT_RSP_OK};
						rcnt <= 4'h1;
					end
				end
			end
			S_PUSH: begin
				if (q_ready) begin
					rbuf <= {8'h00, rbuf[79:8]};
					rcnt <= rcnt - 4'h1;
					if (rcnt == 4'h1) begin
						if (rfinal) begin
							st <= S_IDLE;
						end else begin
							// next consecutive block
							blk_left <= blk_left - 8'h01;
							acc_addr <= acc_addr + 16'h0001;
							acc_req  <= 1'b1;
							st       <= S_ACC;
						end
					end
				end
			end
			default: begin
				st <= S_IDLE;
			end
			endcase
		end
	end
endmodule // vt_cmd_decoder

//--- test/vt_cmd_decoder_props.sv
`include "vt_consts.vh"

module vt_cmd_decoder_chk (
	input wire        clk,
	input wire        rst_n,
	input wire        rx_sof,
	input wire        rx_valid,
	input wire [7:0]  rx_data,
	input wire        rx_eof,
	input wire        rx_crc_ok,
	input wire        tx_valid,
	input wire [7:0]  tx_data,
	input wire        tx_last,
	input wire        tx_ready,
	input wire        acc_req,
	input wire [2:0]  acc_target,
	input wire        acc_write,
	input wire [15:0] acc_addr,
	input wire [15:0] acc_wdata,
	input wire [7:0]  acc_spi_op,
	input wire        acc_done,
	input wire        tag_quiet
);
	timeunit 1ns;
	timeprecision 1ps;
	reg [4:0] bcnt;
	reg [7:0] op;
	reg       first;
	reg       err_r;
	reg [3:0] rtr_age;

	// ****
	// frame and reply tracking
	// ****
	always @(posedge clk) begin
		if (!rst_n) begin
			bcnt <= 5'h00;
			op <= 8'h00;
			first <= 1'b1;
			err_r <= 1'b0;
			rtr_age <= 4'hF;
		end else begin
			if (rx_sof)
				bcnt <= 5'h00;
			else if (rx_valid && bcnt != 5'h1F)
				bcnt <= bcnt + 5'h01;
			if (rx_valid && bcnt == 5'h01)
				op <= rx_data;
			if (tx_valid && tx_ready) begin
				first <= tx_last;
				if (first)
					err_r <= (tx_data == `VT_RSP_ERR);
			end
			// exit window: state may settle a few cycles after eof
			if (rx_eof && rx_crc_ok && op == `VT_OP_RTR)
				rtr_age <= 4'h0;
			else if (rtr_age != 4'hF)
				rtr_age <= rtr_age + 4'h1;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_req_hold: assert property (acc_req && !acc_done |=> acc_req
		&& $stable(acc_target) && $stable(acc_addr) && $stable(acc_write)
		&& $stable(acc_wdata) && $stable(acc_spi_op))
		else $error("access request changed before done");
	chk_req_end: assert property (acc_req && acc_done |=> !acc_req)
		else $error("access request held after done");
	chk_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid
		&& $stable(tx_data) && $stable(tx_last))
		else $error("reply byte changed before taken");
	chk_flag_byte: assert property (tx_valid && first
		|-> tx_data == `VT_RSP_OK || tx_data == `VT_RSP_ERR)
		else $error("bad reply flags byte");
	chk_err_code: assert property (tx_valid && first
		&& tx_data == `VT_RSP_ERR |-> !tx_last)
		else $error("error reply without code");
	chk_err_len: assert property (tx_valid && tx_ready && !first
		&& err_r |-> tx_last)
		else $error("error reply too long");
	chk_crc_drop: assert property (rx_eof && !rx_crc_ok && !tx_valid
		&& !acc_req |=> (!tx_valid && !acc_req) [*8])
		else $error("bad frame acted upon");
	chk_quiet_mute: assert property (rx_eof && rx_crc_ok && !tx_valid
		&& (op == `VT_OP_QUIET || tag_quiet && op != `VT_OP_RTR)
		|=> (!tx_valid && !acc_req) [*8])
		else $error("quiet tag answered");
	chk_quiet_exit: assert property ($fell(tag_quiet) |-> rtr_age < 4'hA)
		else $error("quiet left without reset to ready");

	cover property (acc_req && acc_done && acc_write);
	cover property (tx_valid && !tx_ready && !first);
	cover property ($rose(tag_quiet));
endmodule // vt_cmd_decoder_chk

bind vt_cmd_decoder vt_cmd_decoder_chk u_chk (.clk(clk), .rst_n(rst_n),
	.rx_sof(rx_sof), .rx_valid(rx_valid), .rx_data(rx_data),
	.rx_eof(rx_eof), .rx_crc_ok(rx_crc_ok), .tx_valid(tx_valid),
	.tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
	.acc_req(acc_req), .acc_target(acc_target), .acc_write(acc_write),
	.acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_spi_op(acc_spi_op),
	.acc_done(acc_done), .tag_quiet(tag_quiet));

//--- test/vt_reader_model.sv
module vt_reader_model (
	input wire        clk,
	output reg        rx_sof,
	output reg        rx_valid,
	output reg [7:0]  rx_data,
	output reg        rx_eof,
	output reg        rx_crc_ok,
	input wire        tx_valid,
	input wire [7:0]  tx_data,
	input wire        tx_last,
	output reg        tx_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] fb [0:19];
	logic [7:0] rsp [$];
	int         nrsp = 0;
	int         stall = 0;

	initial begin
		rx_sof = 1'b0;
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_eof = 1'b0;
		rx_crc_ok = 1'b0;
		tx_ready = 1'b1;
	end

	// frame of flags, opcode, args; crc verdict given with eof
	task automatic send(input int n, input bit ok);
		@(posedge clk) rx_sof <= 1'b1;
		for (int i = 0; i < n; i++) begin
			@(posedge clk) rx_sof <= 1'b0;
			rx_valid <= 1'b1;
			rx_data <= fb[i];
		end
		@(posedge clk) rx_sof <= 1'b0;
		rx_valid <= 1'b0;
		// idle data line shows no stale byte
		rx_data <= ~rx_data;
		rx_eof <= 1'b1;
		rx_crc_ok <= ok;
		@(posedge clk) rx_eof <= 1'b0;
		rx_crc_ok <= 1'b0;
	endtask

	always @(posedge clk) begin
		if (tx_valid && tx_ready) begin
			rsp.push_back(tx_data);
			if (tx_last)
				nrsp <= nrsp + 1;
		end
		if (stall > 0)
			stall <= stall - 1;
		tx_ready <= (stall <= 1);
	end
endmodule // vt_reader_model

//--- test/vt_cmd_decoder_tb_top.sv
`include "vt_consts.vh"

module vt_cmd_decoder_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam [63:0] UID = 64'h8877_6655_4433_2211;
	localparam [7:0]  MFG = 8'h5A; // arbitrary value
	localparam logic [7:0] XOP [15] = '{8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hA4,
		8'hA5, 8'hA6, 8'hA7, 8'hA8, 8'hA9, 8'hB0, 8'hB1, 8'hC0, 8'hD0, 8'hD1};
	localparam int XNA [15] = '{1, 3, 1, 3, 2, 4, 1, 3, 1, 0, 1, 1, 0, 1, 1};
	localparam int XTG [15] = '{1, 1, 2, 2, 3, 3, 4, 4, 4, 4, 7, 7, 6, 5, 5};
	localparam int XRL [15] = '{3, 1, 3, 1, 3, 1, 1, 1, 1, 3, 1, 1, 1, 1, 1};
	reg         clk = 1'b0;
	reg         rst_n = 1'b0;
	reg         acc_done = 1'b0;
	reg         acc_err = 1'b0;
	reg  [15:0] acc_rdata = 16'h0000;
	wire        rx_sof, rx_valid, rx_eof, rx_crc_ok;
	wire        tx_valid, tx_last, tx_ready, acc_req, acc_write;
	wire        tag_quiet, tag_selected;
	wire [7:0]  rx_data, tx_data, acc_spi_op, dev_lock;
	wire [2:0]  acc_target;
	wire [15:0] acc_addr, acc_wdata;
	logic [7:0] f [0:19];
	logic [7:0] r [$];
	int         fn, cnt = 0, n_acc = 0, err_count = 0, n_checks = 0;
	logic [2:0] l_tgt;
	logic       l_wr;
	logic [15:0] l_adr, l_wd;
	logic [7:0] l_op;

	always #5 clk = ~clk;

	vt_cmd_decoder #(.MFG_CODE(MFG)) u_dut (.clk(clk), .rst_n(rst_n),
		.ce(1'b1), .uid(UID), .spi_wrsr_op(8'h3C), .spi_rdsr_op(8'hC3),
		.rx_sof(rx_sof), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_eof(rx_eof), .rx_crc_ok(rx_crc_ok), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
		.acc_req(acc_req), .acc_target(acc_target), .acc_write(acc_write),
		.acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_spi_op(acc_spi_op),
		.acc_rdata(acc_rdata), .acc_done(acc_done), .acc_err(acc_err),
		.dev_lock(dev_lock), .tag_quiet(tag_quiet),
		.tag_selected(tag_selected));

	vt_reader_model u_rdr (.clk(clk), .rx_sof(rx_sof), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_eof(rx_eof), .rx_crc_ok(rx_crc_ok),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
		.tx_ready(tx_ready));

	// ****
	// access side: fixed latency, block EE fails
	// ****
	always @(posedge clk) begin
		acc_done <= 1'b0;
		acc_rdata <= ~acc_rdata;
		if (acc_req && !acc_done) begin
			cnt <= cnt + 1;
			if (cnt == 3) begin
				cnt <= 0;
				acc_done <= 1'b1;
				acc_err <= (acc_addr[7:0] == 8'hEE);
				acc_rdata <= {~acc_addr[7:0], acc_addr[7:0]};
				{l_tgt, l_wr, l_adr, l_wd, l_op} <= {acc_target, acc_write,
					acc_addr, acc_wdata, acc_spi_op};
				n_acc <= n_acc + 1;
			end
		end
	end

	// ****
	// helpers
	// ****
	task check(input logic [23:0] seen, input logic [23:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task test_done;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task put(input logic [7:0] b);
		f[fn] = b;
		fn++;
	endtask

	task hdr(input logic [7:0] fl, input logic [7:0] op, input bit ext);
		fn = 0;
		put(fl);
		put(op);
		if (ext) put(MFG);
		if (fl[5]) for (int i = 0; i < 8; i++) put(UID[8*i+:8]);
	endtask

	// no reply expected means waiting out the whole bound
	task run(input bit ok, input int exp);
		int base;
		int k;
		base = u_rdr.nrsp;
		for (int i = 0; i < fn; i++) u_rdr.fb[i] = f[i];
		u_rdr.rsp.delete();
		u_rdr.send(fn, ok);
		for (k = 0; k < 300 && u_rdr.nrsp == base; k++) @(posedge clk);
		if (exp > 0 && k == 300) begin
			err_count++;
			test_done;
		end
		r = u_rdr.rsp;
		check(24'(r.size()), 24'(exp));
		@(posedge clk);
	endtask

	// ****
	// scenarios
	// ****
	task t_read;
		hdr(8'h02, `VT_OP_RD_BLK, 0);
		put(8'h05);
		run(1, 3);
		check({r[0], r[2], r[1]}, {`VT_RSP_OK, 16'hFA05});
		check({l_wr, l_tgt, l_adr}, {1'b0, `VT_TGT_EE, 16'h0005});
		f[2] = 8'hEE;
		run(1, 2);
		check({r[0], r[1]}, {`VT_RSP_ERR, `VT_ERR_ACC});
	endtask

	task t_write;
		hdr(8'h42, `VT_OP_WR_BLK, 0);
		put(8'h07);
		put(8'h34);
		put(8'h12);
		run(1, 1);
		check({r[0], l_wd}, {`VT_RSP_OK, 16'h1234});
		check({l_wr, l_tgt, l_adr}, {1'b1, `VT_TGT_EE, 16'h0007});
		f[0] = 8'h02;
		run(1, 2);
		check({r[0], r[1]}, {`VT_RSP_ERR, `VT_ERR_OPT});
	endtask

	task t_multi;
		int a0;
		logic [7:0] b;
		a0 = n_acc;
		// reader stalls so the reply fifo fills up and holds
		u_rdr.stall = 100;
		hdr(8'h02, `VT_OP_RD_MULTI, 0);
		put(8'h10);
		put(8'h05);
		run(1, 13);
		check(24'(n_acc - a0), 24'h6);
		for (int i = 0; i < 6; i++) begin
			b = 8'h10 + 8'(i);
			check({r[2*i+2], r[2*i+1]}, {~b, b});
		end
	endtask

	task t_ext;
		for (int i = 0; i < 15; i++) begin
			hdr(8'h02, XOP[i], 1);
			for (int j = 0; j < XNA[i]; j++) put(8'h02);
			run(1, XRL[i]);
			check(r[0], `VT_RSP_OK);
			if (XTG[i] < 7) check(l_tgt, XTG[i][2:0]);
			if (XOP[i][7:1] == 7'h54)
				check(l_op, XOP[i][0] ? 8'hC3 : 8'h3C);
			// forwarded opcode comes from the frame; address too for 8'hA7, zero for 8'hA6
			if (XOP[i][7:1] == 7'h53)
				check({l_op, l_adr}, XOP[i][0] ? 24'h020202 : 24'h020000);
		end
		hdr(8'h02, `VT_OP_RD_RF, 0);
		put(8'h5B);
		put(8'h01);
		run(1, 0);
	endtask

	task t_lock;
		for (int k = 0; k < 2; k++) begin
			hdr(8'h02, k ? `VT_OP_ULCK_DEV : `VT_OP_LOCK_DEV, 1);
			put(8'h00);
			run(1, 1);
			check(dev_lock[0], !k);
			hdr(8'h02, `VT_OP_RD_BLK, 0);
			put(8'h05);
			run(1, k ? 3 : 2);
			check(r[1], k ? 8'h05 : `VT_ERR_LOCK);
		end
	endtask

	task t_inv;
		for (int m = 1; m >= 0; m--) begin
			hdr(8'h06, `VT_OP_INVENTORY, 0);
			put(8'h08);
			put(UID[7:0] ^ 8'(m));
			run(1, m ? 0 : 10);
		end
		check({r[0], r[1]}, {`VT_RSP_OK, `VT_DSFID});
		for (int i = 0; i < 8; i++) check(r[2+i], UID[8*i+:8]);
	endtask

	task t_quiet;
		hdr(8'h22, `VT_OP_QUIET, 0);
		run(1, 0);
		check(tag_quiet, 1'b1);
		hdr(8'h02, `VT_OP_RD_BLK, 0);
		put(8'h05);
		run(1, 0);
		hdr(8'h22, `VT_OP_RTR, 0);
		run(1, 1);
		check({tag_quiet, r[0]}, 24'h0);
	endtask

	task t_sel;
		hdr(8'h22, `VT_OP_SELECT, 0);
		f[2] = ~f[2];
		run(1, 0);
		check(tag_selected, 1'b0);
		f[2] = ~f[2];
		run(1, 1);
		check({tag_selected, r[0]}, {1'b1, `VT_RSP_OK});
		// select flag set: answered only while selected
		hdr(8'h12, `VT_OP_RD_BLK, 0);
		put(8'h05);
		run(1, 3);
		hdr(8'h22, `VT_OP_RTR, 0);
		run(1, 1);
		check(tag_selected, 1'b0);
		hdr(8'h12, `VT_OP_RD_BLK, 0);
		put(8'h05);
		run(1, 0);
	endtask

	task t_bad;
		hdr(8'h02, `VT_OP_RD_BLK, 0);
		put(8'h05);
		run(0, 0);
		hdr(8'h02, 8'h99, 0);
		run(1, 0);
	endtask

	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		t_read;
		t_write;
		t_multi;
		t_ext;
		t_lock;
		t_inv;
		t_quiet;
		t_sel;
		t_bad;
		test_done;
	end
endmodule // vt_cmd_decoder_tb_top
